// ### shared/sic_pkg.sv
package sic_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [3:0] SIC_ADDR_TX_STATE = 4'h4;
	localparam logic [3:0] SIC_ADDR_THRESHOLD = 4'h5;
	localparam logic [3:0] SIC_ADDR_SYM_FIRST = 4'h6;
	localparam logic [3:0] SIC_ADDR_SYM_SECOND = 4'h7;
	localparam logic [3:0] SIC_ADDR_CUR_COUNT = 4'h9;

	// ----------------------------------------------------------------
	// Transmit state control fields
	// ----------------------------------------------------------------
	localparam int SIC_TM_LSB = 0;
	localparam int SIC_IC_LOW_BIT = 3;
	localparam int SIC_IC_HIGH_BIT = 4;
	localparam int SIC_SE_BIT = 5;
	localparam int SIC_PAR_BIT = 6;
	localparam int SIC_RES_BIT = 7;
	localparam logic [7:0] SIC_TX_STATE_RESET = 8'ha2;
	localparam logic [7:0] SIC_SYM_RESET = 8'he0;
	localparam logic [7:0] SIC_THRESHOLD_RESET = 8'h00;
	localparam logic [7:0] SIC_COUNT_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Injection modes
	// ----------------------------------------------------------------
	localparam logic [1:0] SIC_MODE_NONE = 2'h0;
	localparam logic [1:0] SIC_MODE_ONESHOT = 2'h1;
	localparam logic [1:0] SIC_MODE_PERIODIC = 2'h2;
	localparam logic [1:0] SIC_MODE_CONTINUOUS = 2'h3;

	// ----------------------------------------------------------------
	// Symbols and timing
	// ----------------------------------------------------------------
	localparam int SIC_SYM_W = 5;
	localparam logic [4:0] SIC_SYM_J = 5'h18;
	localparam logic [4:0] SIC_SYM_K = 5'h11;
	localparam int SIC_CLK_PERIOD_PS = 4000;
	localparam int SIC_PAIR_PERIOD_PS = 80000;
	localparam int SIC_PAIR_CYCLES = (SIC_PAIR_PERIOD_PS + SIC_CLK_PERIOD_PS - 1)
		/ SIC_CLK_PERIOD_PS;

endpackage : sic_pkg

// ### hdl/sic_pair_timer.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Pair period tick: one pulse every 80 ns of clk_i
// ----------------------------------------------------------------
module sic_pair_timer #(
	parameter int CYCLES = sic_pkg::SIC_PAIR_CYCLES
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	output logic tick_o
);
	import sic_pkg::*;

	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;

	always_comb begin
		if (cnt_reg == 8'(CYCLES - 1)) begin
			cnt_next = 8'h00;
		end else begin
			cnt_next = cnt_reg + 8'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			cnt_reg <= 8'h00;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	assign tick_o = (cnt_reg == 8'(CYCLES - 1));

endmodule : sic_pair_timer

// ### hdl/sic_pair_sync.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Two-stage synchroniser for a bundle of pin inputs
// ----------------------------------------------------------------
module sic_pair_sync #(
	parameter int W = 10
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	import sic_pkg::*;

	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			s1_reg <= '0;
			s2_reg <= '0;
		end else begin
			s1_reg <= d_i;
			s2_reg <= s1_reg;
		end
	end

	assign q_o = s2_reg;

endmodule : sic_pair_sync

// ### hdl/sic_injection_ctrl.sv
`timescale 1ns/10ps
// Summary of operation
// R1: Two-bit injection control field selects none, one-shot, periodic or continuous mode.
// R2: Injected pair overrides smoother, repeat filter, encoder and transmit mode output.
// R3: Mode none passes request data unchanged.
// R4: One-shot injects the pair threshold pairs after a JK pair.
// R5: One-shot with threshold zero replaces the JK pair itself.
// R6: After the one-shot injection the low control bit clears itself.
// R7: Software may poll the low control bit to see one-shot completion.
// R8: Periodic mode injects on every (threshold+1)th symbol pair.
// R9: Periodic with threshold zero replaces every data pair.
// R10: Continuous mode replaces every data pair regardless of counter.
// R11: Counter reloads from threshold at zero and on each threshold write.
// R12: Counter is eight bits and decrements once per 80 ns pair period.
// R13: Current counter value is readable in the current count register.
// R14: Counter counts only in one-shot or periodic mode, else holds.
// R15: In periodic, or in one-shot once armed by a JK pair, the pair is substituted when the counter hits zero.
// R16: Counter is zero during reset.
// R17: Threshold register is eight bits, bit 0 least significant.
// R18: Transmit state bit 6 enables request-data parity checking.
// R19: Transmit state bit 7 resets to one and has no effect.
// R20: Each injection symbol register holds one ready 5B symbol.
// R21: First register gives the first symbol, second register the second.
module sic_injection_ctrl #(
	parameter int PAIR_CYCLES = sic_pkg::SIC_PAIR_CYCLES
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	// Control bus
	input wire logic [3:0] cb_addr_i,
	input wire logic cb_wr_i,
	input wire logic [7:0] cb_wdata_i,
	output logic [7:0] cb_rdata_o,
	// Request pair from upstream, asynchronous to clk_i
	input wire logic [sic_pkg::SIC_SYM_W-1:0] req_sym_first_i,
	input wire logic [sic_pkg::SIC_SYM_W-1:0] req_sym_second_i,
	// Transmit pair after injection
	output logic [sic_pkg::SIC_SYM_W-1:0] tx_sym_first_o,
	output logic [sic_pkg::SIC_SYM_W-1:0] tx_sym_second_o,
	output logic tx_pair_valid_o,
	output logic tx_injected_o,
	// Configuration seen by the rest of the transmitter
	output logic [2:0] transmit_mode_o,
	output logic smoother_enable_o,
	output logic request_parity_enable_o
);
	import sic_pkg::*;

	// ----------------------------------------------------------------
	// Pin input synchronisation and pair timing
	// ----------------------------------------------------------------
	logic [2*SIC_SYM_W-1:0] req_sync;
	logic pair_tick;

	// Both symbols cross together and are qualified below
	sic_pair_sync #(
		.W(2 * SIC_SYM_W)
	) u_sync (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.d_i({req_sym_first_i, req_sym_second_i}),
		.q_o(req_sync)
	);

	// One tick per symbol pair period
	sic_pair_timer #(
		.CYCLES(PAIR_CYCLES)
	) u_timer (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.tick_o(pair_tick) // R12
	);

	// ----------------------------------------------------------------
	// Request word capture
	// ----------------------------------------------------------------
	// The pair crosses as a word: take it only once it held for a full
	// cycle, so a change caught half way never reaches the pair tick
	logic [2*SIC_SYM_W-1:0] req_prev_reg;
	logic [2*SIC_SYM_W-1:0] req_prev_next;
	logic [2*SIC_SYM_W-1:0] req_word_reg;
	logic [2*SIC_SYM_W-1:0] req_word_next;

	always_comb begin
		req_prev_next = req_sync;
		req_word_next = req_word_reg;
		if (req_sync == req_prev_reg) begin
			req_word_next = req_sync;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			req_prev_reg <= '0;
			req_word_reg <= '0;
		end else begin
			req_prev_reg <= req_prev_next;
			req_word_reg <= req_word_next;
		end
	end

	logic [SIC_SYM_W-1:0] in_first;
	logic [SIC_SYM_W-1:0] in_second;
	assign in_first = req_word_reg[2*SIC_SYM_W-1:SIC_SYM_W];
	assign in_second = req_word_reg[SIC_SYM_W-1:0];

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] tx_state_reg;
	logic [7:0] tx_state_next;
	logic [7:0] threshold_reg;
	logic [7:0] threshold_next;
	logic [7:0] sym_first_reg;
	logic [7:0] sym_first_next;
	logic [7:0] sym_second_reg;
	logic [7:0] sym_second_next;
	logic [7:0] count_reg;
	logic [7:0] count_next;
	logic armed_reg;
	logic armed_next;
	logic [SIC_SYM_W-1:0] out_first_reg;
	logic [SIC_SYM_W-1:0] out_first_next;
	logic [SIC_SYM_W-1:0] out_second_reg;
	logic [SIC_SYM_W-1:0] out_second_next;
	logic valid_reg;
	logic valid_next;
	logic injected_reg;
	logic injected_next;

	logic [1:0] mode;
	logic is_jk;
	logic counting;
	logic inject;
	logic oneshot_done;
	logic wr_state;
	logic wr_thr;

	assign mode = {tx_state_reg[SIC_IC_HIGH_BIT], tx_state_reg[SIC_IC_LOW_BIT]}; // R1
	assign is_jk = (in_first == SIC_SYM_J) && (in_second == SIC_SYM_K);
	assign wr_state = cb_wr_i && (cb_addr_i == SIC_ADDR_TX_STATE);
	assign wr_thr = cb_wr_i && (cb_addr_i == SIC_ADDR_THRESHOLD);
	assign counting = (mode == SIC_MODE_ONESHOT) || (mode == SIC_MODE_PERIODIC); // R14

	// ----------------------------------------------------------------
	// Injection decision per pair
	// ----------------------------------------------------------------
	always_comb begin
		inject = 1'b0;
		oneshot_done = 1'b0;
		unique case (mode)
			SIC_MODE_NONE: begin
				inject = 1'b0; // R3
			end
			SIC_MODE_ONESHOT: begin
				// Zero threshold hits the JK pair itself, else n pairs later
				if (is_jk && threshold_reg == 8'h00) begin
					inject = 1'b1; // R5
				end else if (armed_reg && count_reg == 8'h00) begin
					inject = 1'b1; // R4 R15
				end
				oneshot_done = inject && pair_tick; // R6
			end
			SIC_MODE_PERIODIC: begin
				inject = (count_reg == 8'h00); // R8 R9 R15
			end
			SIC_MODE_CONTINUOUS: begin
				inject = 1'b1; // R10
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Counter and one-shot arming
	// ----------------------------------------------------------------
	always_comb begin
		count_next = count_reg;
		armed_next = armed_reg;
		// A threshold write restarts the count even in mid period
		if (wr_thr) begin
			count_next = cb_wdata_i; // R11
		end else if (pair_tick && counting) begin
			if (mode == SIC_MODE_ONESHOT && is_jk && !armed_reg) begin
				// Start the delay from the JK pair
				armed_next = (threshold_reg != 8'h00);
				count_next = threshold_reg - 8'h01;
				if (threshold_reg == 8'h00) begin
					count_next = threshold_reg;
				end
			end else if (count_reg == 8'h00) begin
				// Wrap: the next period starts from the threshold
				count_next = threshold_reg; // R11
			end else begin
				count_next = count_reg - 8'h01; // R12
			end
		end
		if (pair_tick && oneshot_done) begin
			armed_next = 1'b0;
		end
		if (!(mode == SIC_MODE_ONESHOT)) begin
			armed_next = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	always_comb begin
		tx_state_next = tx_state_reg;
		threshold_next = threshold_reg;
		sym_first_next = sym_first_reg;
		sym_second_next = sym_second_reg;
		if (wr_state) begin
			tx_state_next = cb_wdata_i; // R18 R19
		end
		if (wr_thr) begin
			threshold_next = cb_wdata_i; // R17
		end
		if (cb_wr_i && cb_addr_i == SIC_ADDR_SYM_FIRST) begin
			sym_first_next = cb_wdata_i;
		end
		if (cb_wr_i && cb_addr_i == SIC_ADDR_SYM_SECOND) begin
			sym_second_next = cb_wdata_i;
		end
		// Hardware clear wins over a simultaneous software write of the bit
		if (oneshot_done) begin
			tx_state_next[SIC_IC_LOW_BIT] = 1'b0; // R6 R7
		end
	end

	// ----------------------------------------------------------------
	// Output pair
	// ----------------------------------------------------------------
	always_comb begin
		out_first_next = out_first_reg;
		out_second_next = out_second_reg;
		injected_next = injected_reg;
		// Pair and injected flag move only on the pair tick, so each pair stands one period
		valid_next = pair_tick;
		if (pair_tick) begin
			if (inject) begin
				out_first_next = sym_first_reg[SIC_SYM_W-1:0]; // R2 R20 R21
				out_second_next = sym_second_reg[SIC_SYM_W-1:0]; // R21
			end else begin
				out_first_next = in_first; // R3
				out_second_next = in_second;
			end
			injected_next = inject;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			tx_state_reg <= SIC_TX_STATE_RESET; // R19
			threshold_reg <= SIC_THRESHOLD_RESET;
			sym_first_reg <= SIC_SYM_RESET;
			sym_second_reg <= SIC_SYM_RESET;
			count_reg <= SIC_COUNT_RESET; // R16
			armed_reg <= 1'b0;
			out_first_reg <= '0;
			out_second_reg <= '0;
			valid_reg <= 1'b0;
			injected_reg <= 1'b0;
		end else begin
			tx_state_reg <= tx_state_next;
			threshold_reg <= threshold_next;
			sym_first_reg <= sym_first_next;
			sym_second_reg <= sym_second_next;
			count_reg <= count_next;
			armed_reg <= armed_next;
			out_first_reg <= out_first_next;
			out_second_reg <= out_second_next;
			valid_reg <= valid_next;
			injected_reg <= injected_next;
		end
	end

	// ----------------------------------------------------------------
	// Read mux and status outputs
	// ----------------------------------------------------------------
	always_comb begin
		// Unmapped addresses read as zero; the count register ignores writes
		unique case (cb_addr_i)
			SIC_ADDR_TX_STATE: cb_rdata_o = tx_state_reg;
			SIC_ADDR_THRESHOLD: cb_rdata_o = threshold_reg;
			SIC_ADDR_SYM_FIRST: cb_rdata_o = sym_first_reg;
			SIC_ADDR_SYM_SECOND: cb_rdata_o = sym_second_reg;
			SIC_ADDR_CUR_COUNT: cb_rdata_o = count_reg; // R13
			default: cb_rdata_o = 8'h00;
		endcase
	end

	assign tx_sym_first_o = out_first_reg;
	assign tx_sym_second_o = out_second_reg;
	assign tx_pair_valid_o = valid_reg;
	assign tx_injected_o = injected_reg;
	assign transmit_mode_o = tx_state_reg[SIC_TM_LSB+2:SIC_TM_LSB];
	assign smoother_enable_o = tx_state_reg[SIC_SE_BIT];
	assign request_parity_enable_o = tx_state_reg[SIC_PAR_BIT]; // R18

endmodule : sic_injection_ctrl

// ### tb/sic_asserts.sv
`timescale 1ns/10ps
module sic_asserts import sic_pkg::*; #(
	parameter int PAIR_CYCLES = SIC_PAIR_CYCLES
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [3:0] cb_addr_i,
	input wire logic cb_wr_i,
	input wire logic [7:0] cb_wdata_i,
	input wire logic [7:0] cb_rdata_o,
	input wire logic [4:0] tx_sym_first_o,
	input wire logic [4:0] tx_sym_second_o,
	input wire logic tx_pair_valid_o,
	input wire logic tx_injected_o,
	input wire logic [2:0] transmit_mode_o,
	input wire logic request_parity_enable_o
);
	// --------
	// Shadow of written settings
	// --------
	logic [1:0] ic_reg;
	logic [4:0] s1_reg, s2_reg;
	logic stl_reg, seen_reg;
	logic [7:0] gap_reg;
	wire logic wr4 = cb_wr_i && cb_addr_i == SIC_ADDR_TX_STATE;
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			ic_reg <= 2'h0;
			stl_reg <= 1'b0;
			seen_reg <= 1'b0;
			gap_reg <= 8'h00;
			s1_reg <= 5'h00;
			s2_reg <= 5'h00;
		end else begin
			seen_reg <= seen_reg | tx_pair_valid_o;
			gap_reg <= tx_pair_valid_o ? 8'h00 : gap_reg + 8'h01;
			stl_reg <= wr4 ? 1'b0 : (stl_reg | tx_pair_valid_o);
			if (wr4) ic_reg <= cb_wdata_i[4:3];
			if (cb_wr_i && cb_addr_i == SIC_ADDR_SYM_FIRST) s1_reg <= cb_wdata_i[4:0];
			if (cb_wr_i && cb_addr_i == SIC_ADDR_SYM_SECOND) s2_reg <= cb_wdata_i[4:0];
		end
	end
	// --------
	// Properties
	// --------
	default clocking dck @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	sequence s_thr_wr;
		cb_wr_i && cb_addr_i == SIC_ADDR_THRESHOLD;
	endsequence
	a_reset_idle: assert property ($past(!rstn_i) |-> !tx_pair_valid_o && !tx_injected_o)
		else $error("outputs not idle after reset");
	a_thresh_read: assert property (s_thr_wr |=> cb_addr_i != SIC_ADDR_THRESHOLD
		|| cb_rdata_o == $past(cb_wdata_i)) else $error("threshold readback wrong");
	a_count_reload: assert property (s_thr_wr |=> cb_addr_i != SIC_ADDR_CUR_COUNT
		|| cb_rdata_o == $past(cb_wdata_i)) else $error("count not reloaded");
	a_cfg_bits: assert property ($past(wr4) |-> request_parity_enable_o == $past(cb_wdata_i[6])
		&& transmit_mode_o == $past(cb_wdata_i[2:0])) else $error("config bits wrong");
	a_none_pass: assert property (tx_pair_valid_o && stl_reg && ic_reg == 2'h0 |-> !tx_injected_o)
		else $error("injection in mode none");
	a_cont_all: assert property (tx_pair_valid_o && stl_reg && ic_reg == 2'h3 |-> tx_injected_o)
		else $error("pair not injected in continuous");
	a_inj_syms: assert property (tx_pair_valid_o && tx_injected_o |-> tx_sym_first_o == s1_reg
		&& tx_sym_second_o == s2_reg) else $error("injected symbols wrong");
	a_valid_period: assert property (tx_pair_valid_o && seen_reg |-> gap_reg == 8'(PAIR_CYCLES - 1))
		else $error("pair period wrong");
endmodule : sic_asserts

// ### tb/sic_req_model.sv
`timescale 1ns/10ps
module sic_req_model import sic_pkg::*; #(
	parameter int HOLD = 4
) (
	input wire logic clk_i,
	input wire logic jk_i,
	output logic [4:0] first_o,
	output logic [4:0] second_o
);
	// Each pair stands one full pair period; data never looks like J or K
	logic [7:0] cnt = 8'h00;
	logic [3:0] dat = 4'h0;
	logic pend = 1'b0;
	initial first_o = 5'h00;
	initial second_o = 5'h0f;
	always @(posedge clk_i) begin
		cnt <= (cnt == 8'(HOLD - 1)) ? 8'h00 : cnt + 8'h01;
		if (jk_i) pend <= 1'b1;
		if (cnt == 8'(HOLD - 1)) begin
			if (pend) begin
				first_o <= SIC_SYM_J;
				second_o <= SIC_SYM_K;
				pend <= 1'b0;
			end else begin
				dat <= dat + 4'h1;
				first_o <= {1'b0, dat + 4'h1};
				second_o <= {1'b0, ~(dat + 4'h1)};
			end
		end
	end
endmodule : sic_req_model

// ### tb/testbench.sv
`timescale 1ns/10ps
module testbench;
	import sic_pkg::*;
	localparam int PC = 4;
	logic clk_i = 1'b0, rstn_i = 1'b0, cb_wr_i = 1'b0, jk_i = 1'b0;
	logic [3:0] cb_addr_i = 4'h0;
	logic [7:0] cb_wdata_i = 8'h00, cb_rdata_o;
	logic [4:0] rq1, rq2, tx_sym_first_o, tx_sym_second_o;
	logic tx_pair_valid_o, tx_injected_o, smoother_enable_o, request_parity_enable_o;
	logic [2:0] transmit_mode_o;
	int error_cnt = 0, compares = 0;
	always #2 clk_i = ~clk_i;
	sic_injection_ctrl #(.PAIR_CYCLES(PC)) dut_u (.clk_i(clk_i), .rstn_i(rstn_i),
		.cb_addr_i(cb_addr_i), .cb_wr_i(cb_wr_i), .cb_wdata_i(cb_wdata_i),
		.cb_rdata_o(cb_rdata_o), .req_sym_first_i(rq1), .req_sym_second_i(rq2),
		.tx_sym_first_o(tx_sym_first_o), .tx_sym_second_o(tx_sym_second_o),
		.tx_pair_valid_o(tx_pair_valid_o), .tx_injected_o(tx_injected_o),
		.transmit_mode_o(transmit_mode_o), .smoother_enable_o(smoother_enable_o),
		.request_parity_enable_o(request_parity_enable_o));
	sic_req_model #(.HOLD(PC)) mac_u (.clk_i(clk_i), .jk_i(jk_i), .first_o(rq1), .second_o(rq2));
	// --------
	// Shared tasks
	// --------
	task automatic final_report;
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : final_report
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(logic [3:0] a, logic [7:0] d);
		@(posedge clk_i) #1;
		cb_addr_i = a;
		cb_wdata_i = d;
		cb_wr_i = 1'b1;
		@(posedge clk_i) #1;
		cb_wr_i = 1'b0;
	endtask : wr
	task automatic rd(logic [3:0] a, output logic [7:0] d);
		@(posedge clk_i) #1;
		cb_addr_i = a;
		#1 d = cb_rdata_o;
	endtask : rd
	task automatic wv;
		for (int i = 0; i < 50; i++) begin
			@(posedge clk_i) #1;
			if (tx_pair_valid_o === 1'b1) return;
		end
		chk("pair_timeout", 8'h00, 8'h01);
		final_report();
	endtask : wv
	// --------
	// Scenarios
	// --------
	task automatic t_reset;
		logic [3:0] a[6] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'h3};
		logic [7:0] e[6] = '{8'ha2, 8'h00, 8'he0, 8'he0, 8'h00, 8'h00};
		logic [7:0] d;
		for (int i = 0; i < 6; i++) begin
			rd(a[i], d);
			chk("reset_value", e[i], d);
		end
		chk("smoother_on", 8'h01, {7'h00, smoother_enable_o});
		chk("tx_mode_off", 8'h02, {5'h00, transmit_mode_o});
	endtask : t_reset
	task automatic t_regs;
		logic [7:0] d;
		wr(4'h4, 8'hc0);
		chk("parity_on", 8'h01, {7'h00, request_parity_enable_o});
		chk("smoother_off", 8'h00, {7'h00, smoother_enable_o});
		wr(4'h5, 8'ha5);
		cb_addr_i = SIC_ADDR_CUR_COUNT;
		wr(4'h9, 8'h55);
		rd(4'h5, d);
		chk("threshold", 8'ha5, d);
		rd(4'h9, d);
		chk("count_hold", 8'ha5, d);
		wr(4'h6, 8'h1c);
		wr(4'h7, 8'h03);
		rd(4'h7, d);
		chk("sym_second", 8'h03, d);
	endtask : t_regs
	task automatic t_none;
		logic [3:0] p;
		wr(4'h4, 8'h80);
		chk("parity_off", 8'h00, {7'h00, request_parity_enable_o});
		wv;
		wv;
		p = tx_sym_first_o[3:0];
		repeat (4) begin
			wv;
			p = p + 4'h1;
			chk("pass_first", {4'h0, p}, {3'h0, tx_sym_first_o});
			chk("pass_second", {4'h0, ~p}, {3'h0, tx_sym_second_o});
		end
	endtask : t_none
	task automatic t_per(logic [7:0] n);
		logic [7:0] c1, c2;
		int k;
		wr(4'h5, n);
		wr(4'h4, 8'h90);
		wv;
		wv;
		k = 0;
		repeat (6 * (n + 1)) begin
			wv;
			k += tx_injected_o;
		end
		chk("periodic_hits", 8'h06, 8'(k));
		rd(4'h9, c1);
		wv;
		rd(4'h9, c2);
		chk("count_step", (c1 == 8'h00) ? n : c1 - 8'h01, c2);
	endtask : t_per
	task automatic t_cont;
		logic [7:0] d;
		// Leave periodic first, so no pair tick moves the reloaded count
		wr(4'h4, 8'h98);
		wr(4'h5, 8'h02);
		wv;
		repeat (4) begin
			wv;
			chk("cont_inj", 8'h01, {7'h00, tx_injected_o});
			chk("cont_first", 8'h1c, {3'h0, tx_sym_first_o});
			chk("cont_second", 8'h03, {3'h0, tx_sym_second_o});
		end
		rd(4'h9, d);
		chk("cont_count", 8'h02, d);
	endtask : t_cont
	task automatic t_one(logic [7:0] n);
		int j, m;
		logic [7:0] d;
		wr(4'h4, 8'h80);
		wr(4'h5, n);
		wr(4'h4, 8'h88);
		jk_i = 1'b1;
		@(posedge clk_i) #1;
		jk_i = 1'b0;
		j = -1;
		m = 0;
		for (int i = 0; i < 12; i++) begin
			wv;
			if (tx_sym_first_o === SIC_SYM_J && tx_sym_second_o === SIC_SYM_K) j = i;
			if (tx_injected_o === 1'b1) begin
				m++;
				if (n == 8'h00) chk("jk_replaced", 8'hff, 8'(j));
				else chk("oneshot_gap", n, 8'(i - j));
			end
		end
		chk("oneshot_count", 8'h01, 8'(m));
		rd(4'h4, d);
		chk("ic_low_clear", 8'h80, d);
	endtask : t_one
	initial begin
		repeat (3) @(posedge clk_i);
		#1 rstn_i = 1'b1;
		t_reset();
		t_regs();
		t_none();
		t_per(8'h02);
		t_per(8'h00);
		t_cont();
		t_one(8'h02);
		t_one(8'h00);
		final_report();
	end
endmodule : testbench
bind sic_injection_ctrl sic_asserts #(.PAIR_CYCLES(PAIR_CYCLES)) chk_u (.clk_i(clk_i),
	.rstn_i(rstn_i), .cb_addr_i(cb_addr_i), .cb_wr_i(cb_wr_i), .cb_wdata_i(cb_wdata_i),
	.cb_rdata_o(cb_rdata_o), .tx_sym_first_o(tx_sym_first_o),
	.tx_sym_second_o(tx_sym_second_o), .tx_pair_valid_o(tx_pair_valid_o),
	.tx_injected_o(tx_injected_o), .transmit_mode_o(transmit_mode_o),
	.request_parity_enable_o(request_parity_enable_o));
